/* File: rtl/oag_core.sv */
// Operand and branch address generator of an 8-bit CPU core
//
// Function
// RULE1 - Post-increment add_small_constant 1 for byte, 2 for word moves, after the access.
// RULE2 - Pre-decrement subtracts 1 for byte, 2 for word moves, before the access.
// RULE3 - Short absolute byte moves use upper address byte all ones.
// RULE4 - Full 16-bit absolute address for moves, jump and jump to subroutine.
// RULE5 - 8-bit immediate from byte 2; 16-bit immediate from bytes 3 and 4.
// RULE6 - Only the word move may carry a 16-bit immediate.
// RULE7 - Small-constant add and subtract take 1 or 2 from the opcode.
// RULE8 - Bit instructions decode a 3-bit bit number in byte 2 or 4.
// RULE9 - Branch target is PC plus sign-extended byte 2, forced even.
// RULE10 - Branch reach spans 126 bytes back to 128 bytes forward.
// RULE11 - Memory indirect reads the word at zero-page byte 2 as target.
// RULE12 - Software keeps in mind the vector table sits low in that page.
// RULE13 - Odd branch targets and word move addresses drop bit 0.
// RULE14 - Bit instructions act on one bit 0 to 7 of a byte.
// RULE15 - All arithmetic and logic ops take bytes except small-constant ones.
// RULE16 - Decimal adjust corrects each nibble as one packed BCD digit.
// RULE17 - Word operands only for word move, add, sub, compare, small, mul, div.
// RULE18 - Any 16-bit register may be the pointer; register 7 is the stack.
`timescale 1ns/1ps
`default_nettype none

module oag_core
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              req_i,
  input  wire oag_pkg::oag_mode_t mode_i,
  input  wire oag_pkg::oag_op_t  op_i,
  input  wire logic              word_i,
  input  wire logic [2:0]        reg_sel_i,
  input  wire logic [15:0]       ptr_i,
  input  wire logic [15:0]       pc_i,
  input  wire logic [7:0]        ib2_i,
  input  wire logic [15:0]       ext_i,
  input  wire logic              k_two_i,
  input  wire logic              bit_in_b4_i,
  input  wire logic [7:0]        dadj_val_i,
  input  wire logic              dadj_c_i,
  input  wire logic              dadj_h_i,
  input  wire logic              mem_ack_i,
  input  wire logic [15:0]       mem_data_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic [15:0]            ea_o,
  output logic [15:0]            imm_o,
  output logic                   ptr_we_o,
  output logic [2:0]             ptr_sel_o,
  output logic [15:0]            ptr_wdata_o,
  output logic                   sp_used_o,
  output logic [7:0]             bit_mask_o,
  output logic                   mem_rd_o,
  output logic [15:0]            mem_addr_o,
  output logic                   illegal_o,
  output logic                   vec_hit_o,
  output logic [7:0]             dadj_o,
  output logic                   dadj_c_o
);
  import oag_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Word accesses ignore bit 0 of the address
  function automatic logic [15:0] even_addr(input logic [15:0] a);
    even_addr = a & EVEN_MASK; // RULE13
  endfunction

  // Step size from operand size
  function automatic logic [15:0] step_of(input logic w);
    step_of = w ? STEP_WORD : STEP_BYTE;
  endfunction

  // One-hot select of a bit in a byte
  function automatic logic [7:0] bit_sel(input logic [2:0] n);
    bit_sel = 8'h01 << n; // RULE14
  endfunction

  // Packed BCD correction after add or subtract
  function automatic logic [8:0] bcd_fix(
    input logic [7:0] v,
    input logic       c,
    input logic       h,
    input logic       sub
  );
    logic [7:0] fix;
    logic       co;
    fix = RST_BYTE;
    co  = c;
    if (sub)
    begin
      if (h)
        fix = fix | BCD_LO_FIX;
      if (c)
        fix = fix | BCD_HI_FIX;
      bcd_fix = {co, v - fix};
    end
    else
    begin
      if (h || (v[3:0] > BCD_NIB_MAX))
        fix = fix | BCD_LO_FIX;
      if (c || (v > BCD_BYTE_MAX))
      begin
        fix = fix | BCD_HI_FIX;
        co  = 1'b1;
      end
      bcd_fix = {co, v + fix};
    end
  endfunction

  // ----------------------------------------
  // Request classification
  // ----------------------------------------
  logic        word_op;
  logic        small_op;
  logic        bad_req;
  logic [15:0] step;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_inc;
  logic [15:0] br_sum;
  logic [15:0] ind_addr;
  logic [2:0]  bit_num;
  logic [8:0]  dadj_res;

  // Groups allowed to carry word operands
  always_comb
  begin
    case (op_i)
      OAG_OP_MOVE_WORD,
      OAG_OP_ADD_WORD,
      OAG_OP_SUB_WORD,
      OAG_OP_COMPARE_WORD,
      OAG_OP_ADD_SMALL,
      OAG_OP_SUB_SMALL,
      OAG_OP_MULTIPLY,
      OAG_OP_DIVIDE: word_op = 1'b1; // RULE17
      default:       word_op = 1'b0;
    endcase
  end

  assign small_op = (op_i == OAG_OP_ADD_SMALL) || (op_i == OAG_OP_SUB_SMALL);

  // Size and form checks; a refused request does no address work
  always_comb
  begin
    bad_req = 1'b0;
    if ((mode_i == OAG_MD_IMM16) && (op_i != OAG_OP_MOVE_WORD))
      bad_req = 1'b1; // RULE6
    else if (word_i && !word_op)
      bad_req = 1'b1; // RULE17
    else if (!word_i && small_op)
      bad_req = 1'b1; // RULE15
    else if ((mode_i == OAG_MD_ABS8) && (op_i != OAG_OP_MOVE_BYTE))
      bad_req = 1'b1; // RULE3
  end

  // Pointer arithmetic and branch sums
  assign step     = step_of(word_i);
  assign ptr_dec  = ptr_i - step;  // RULE2
  assign ptr_inc  = ptr_i + step;  // RULE1
  // Sign-extended byte gives -128..+127 around the next PC, the even force
  // trims that to the documented -126..+128 around the current one
  assign br_sum   = pc_i + {{8{ib2_i[7]}}, ib2_i}; // RULE9 RULE10
  assign ind_addr = {ZERO_PAGE_HI, ib2_i}; // RULE11
  assign bit_num  = bit_in_b4_i ? ext_i[6:4] : ib2_i[6:4]; // RULE8
  assign dadj_res = bcd_fix(dadj_val_i, dadj_c_i, dadj_h_i,
                            op_i == OAG_OP_DEC_ADJ_SUB); // RULE16

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [0:0] {
    OAG_ST_IDLE,
    OAG_ST_IND
  } oag_state_t;

  oag_state_t state_r;
  oag_state_t state_nxt;
  logic       start;
  logic       ind_done;

  assign start    = (state_r == OAG_ST_IDLE) && req_i;
  assign ind_done = (state_r == OAG_ST_IND) && mem_ack_i;

  // Only the memory indirect mode needs a second step
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      OAG_ST_IDLE:
        if (req_i && !bad_req && (mode_i == OAG_MD_MEMIND))
          state_nxt = OAG_ST_IND;
      OAG_ST_IND:
        if (mem_ack_i)
          state_nxt = OAG_ST_IDLE;
      default:
        state_nxt = OAG_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_r <= OAG_ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Busy mirrors the indirect wait
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      busy_o <= 1'b0;
    else
      busy_o <= (state_nxt == OAG_ST_IND);
  end

  // Done pulses in the same cycle that the address appears on ea_o
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      done_o <= 1'b0;
    else
      done_o <= (start && (bad_req || (mode_i != OAG_MD_MEMIND))) || ind_done;
  end

  // Refused requests flag for one cycle alongside done
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      illegal_o <= 1'b0;
    else
      illegal_o <= start && bad_req;
  end

  // ----------------------------------------
  // Effective address
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ea_o <= RST_WORD;
    else if (ind_done)
      ea_o <= even_addr(mem_data_i); // RULE11 RULE13
    else if (start && !bad_req)
    begin
      case (mode_i)
        OAG_MD_POSTINC:
          ea_o <= word_i ? even_addr(ptr_i) : ptr_i; // RULE1 RULE13
        OAG_MD_PREDEC:
          ea_o <= word_i ? even_addr(ptr_dec) : ptr_dec; // RULE2 RULE13
        OAG_MD_ABS8:
          ea_o <= {TOP_PAGE_HI, ib2_i}; // RULE3
        OAG_MD_ABS16:
          if (word_i || (op_i == OAG_OP_JUMP) || (op_i == OAG_OP_JUMP_SUB))
            ea_o <= even_addr(ext_i); // RULE4 RULE13
          else
            ea_o <= ext_i; // RULE4
        OAG_MD_PCREL:
          ea_o <= even_addr(br_sum); // RULE9 RULE13
        default:
          ea_o <= ea_o;
      endcase
    end
  end

  // ----------------------------------------
  // Immediate and bit select
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      imm_o <= RST_WORD;
    else if (start && !bad_req)
    begin
      case (mode_i)
        OAG_MD_IMM8:   imm_o <= {ZERO_PAGE_HI, ib2_i}; // RULE5
        OAG_MD_IMM16:  imm_o <= ext_i; // RULE5 RULE6
        OAG_MD_SMALLK: imm_o <= k_two_i ? STEP_WORD : STEP_BYTE; // RULE7
        OAG_MD_BITNUM: imm_o <= {13'h0000, bit_num}; // RULE8
        default:       imm_o <= imm_o;
      endcase
    end
  end

  // Mask of the selected bit of the byte operand
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      bit_mask_o <= RST_BYTE;
    else if (start && !bad_req && (mode_i == OAG_MD_BITNUM))
      bit_mask_o <= bit_sel(bit_num); // RULE8 RULE14
  end

  // ----------------------------------------
  // Pointer write-back
  // ----------------------------------------
  // Any of the eight registers may be named; the register file applies it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr_we_o    <= 1'b0;
      ptr_sel_o   <= 3'h0;
      ptr_wdata_o <= RST_WORD;
      sp_used_o   <= 1'b0;
    end
    else
    begin
      ptr_we_o <= start && !bad_req &&
                  ((mode_i == OAG_MD_POSTINC) || (mode_i == OAG_MD_PREDEC));
      if (start && !bad_req)
      begin
        ptr_sel_o <= reg_sel_i; // RULE18
        sp_used_o <= (reg_sel_i == SP_INDEX); // RULE18
        if (mode_i == OAG_MD_POSTINC)
          ptr_wdata_o <= ptr_inc; // RULE1
        else if (mode_i == OAG_MD_PREDEC)
          ptr_wdata_o <= ptr_dec; // RULE2
      end
    end
  end

  // ----------------------------------------
  // Indirect table read
  // ----------------------------------------
  // Read is held until acknowledged; the table word is always even aligned
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_rd_o   <= 1'b0;
      mem_addr_o <= RST_WORD;
      vec_hit_o  <= 1'b0;
    end
    else if (start && !bad_req && (mode_i == OAG_MD_MEMIND))
    begin
      mem_rd_o   <= 1'b1;
      mem_addr_o <= even_addr(ind_addr); // RULE11 RULE13
      vec_hit_o  <= (ind_addr <= VEC_TOP); // RULE12
    end
    else if (ind_done)
      mem_rd_o <= 1'b0;
  end

  // ----------------------------------------
  // Decimal adjust
  // ----------------------------------------
  // Result is only meaningful for the two adjust groups
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dadj_o   <= RST_BYTE;
      dadj_c_o <= 1'b0;
    end
    else if (start && !bad_req && ((op_i == OAG_OP_DEC_ADJ_ADD) ||
                                   (op_i == OAG_OP_DEC_ADJ_SUB)))
    begin
      dadj_o   <= dadj_res[7:0]; // RULE16
      dadj_c_o <= dadj_res[8];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/oag_pkg.sv */
// Package for the operand and branch address generator: types and constants
package oag_pkg;

  // ----------------------------------------
  // Widths and fixed address forms
  // ----------------------------------------
  localparam int          ADDR_W      = 16;
  localparam logic [7:0]  TOP_PAGE_HI = 8'hFF;      // Short absolute page
  localparam logic [7:0]  ZERO_PAGE_HI = 8'h00;     // Indirect table page
  localparam logic [15:0] VEC_TOP     = 16'h003D;   // Last vector table byte
  localparam logic [15:0] STEP_BYTE   = 16'h0001;
  localparam logic [15:0] STEP_WORD   = 16'h0002;
  localparam logic [15:0] EVEN_MASK   = 16'hFFFE;
  localparam logic [2:0]  SP_INDEX    = 3'h7;       // Pointer that is also SP

  // ----------------------------------------
  // Decimal adjust constants
  // ----------------------------------------
  localparam logic [7:0]  BCD_LO_FIX  = 8'h06;
  localparam logic [7:0]  BCD_HI_FIX  = 8'h60;
  localparam logic [3:0]  BCD_NIB_MAX = 4'h9;
  localparam logic [7:0]  BCD_BYTE_MAX = 8'h99;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [7:0]  RST_BYTE    = 8'h00;

  // Addressing mode of the current request
  typedef enum logic [3:0] {
    OAG_MD_POSTINC,
    OAG_MD_PREDEC,
    OAG_MD_ABS8,
    OAG_MD_ABS16,
    OAG_MD_IMM8,
    OAG_MD_IMM16,
    OAG_MD_PCREL,
    OAG_MD_MEMIND,
    OAG_MD_SMALLK,
    OAG_MD_BITNUM
  } oag_mode_t;

  // Instruction group of the current request
  typedef enum logic [4:0] {
    OAG_OP_MOVE_BYTE,
    OAG_OP_MOVE_WORD,
    OAG_OP_JUMP,
    OAG_OP_JUMP_SUB,
    OAG_OP_BRANCH_SUB,
    OAG_OP_BRANCH_COND,
    OAG_OP_ADD_SMALL,
    OAG_OP_SUB_SMALL,
    OAG_OP_DEC_ADJ_ADD,
    OAG_OP_DEC_ADJ_SUB,
    OAG_OP_MULTIPLY,
    OAG_OP_DIVIDE,
    OAG_OP_COMPARE_WORD,
    OAG_OP_ADD_WORD,
    OAG_OP_SUB_WORD,
    OAG_OP_BIT,
    OAG_OP_ALU_BYTE
  } oag_op_t;

endpackage

/* File: verif/oag_mem_model.sv */
// Behavioural model of the zero-page table memory behind the indirect read port
`timescale 1ns/1ps
`default_nettype none

module oag_mem_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [3:0]  dly_i,
  output logic             ack_o,
  output logic [15:0]      data_o
);
  logic [3:0] wait_r;

  // ----------------------------------------
  // Table read with a programmable wait
  // ----------------------------------------
  // Data toggles outside the ack cycle so a stale capture cannot pass
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wait_r <= 4'h0;
      ack_o  <= 1'b0;
      data_o <= 16'h5A5A;
    end
    else
    begin
      ack_o  <= 1'b0;
      data_o <= ~data_o;
      if (rd_i && !ack_o)
      begin
        if (wait_r == dly_i)
        begin
          ack_o  <= 1'b1;
          data_o <= {8'h31, addr_i[7:0] | 8'h01};
          wait_r <= 4'h0;
        end
        else
          wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

/* File: verif/oag_core_properties.sv */
// Port-level timing and value checks for the address generator
`timescale 1ns/1ps
`default_nettype none

module oag_core_properties
  import oag_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               req_i,
  input wire oag_pkg::oag_mode_t mode_i,
  input wire oag_pkg::oag_op_t   op_i,
  input wire logic               word_i,
  input wire logic               k_two_i,
  input wire logic               bit_in_b4_i,
  input wire logic [15:0]        ptr_i,
  input wire logic [15:0]        pc_i,
  input wire logic [7:0]         ib2_i,
  input wire logic [15:0]        ext_i,
  input wire logic               mem_ack_i,
  input wire logic [15:0]        mem_data_i,
  input wire logic               busy_o,
  input wire logic               done_o,
  input wire logic               illegal_o,
  input wire logic               mem_rd_o,
  input wire logic [15:0]        ea_o,
  input wire logic [15:0]        imm_o,
  input wire logic [15:0]        ptr_wdata_o,
  input wire logic [7:0]         bit_mask_o,
  input wire logic [15:0]        mem_addr_o
);
  logic        take;
  logic [15:0] disp;
  logic [2:0]  bnum;

  // ----------------------------------------
  // Request decode seen from the ports
  // ----------------------------------------
  assign take = req_i && !busy_o;
  assign disp = {{8{ib2_i[7]}}, ib2_i};
  assign bnum = bit_in_b4_i ? ext_i[6:4] : ib2_i[6:4];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  done_next_a : assert property (take && mode_i != OAG_MD_MEMIND |=> done_o)
    else $error("no done after request");
  post_inc_step_a : assert property (take && mode_i == OAG_MD_POSTINC && op_i == OAG_OP_MOVE_WORD && word_i
    |=> ptr_wdata_o == $past(ptr_i) + STEP_WORD) else $error("post increment step wrong");
  pre_dec_step_a : assert property (take && mode_i == OAG_MD_PREDEC && op_i == OAG_OP_MOVE_BYTE && !word_i
    |=> ea_o == $past(ptr_i) - STEP_BYTE && ptr_wdata_o == ea_o) else $error("pre decrement wrong");
  short_abs_page_a : assert property (take && mode_i == OAG_MD_ABS8 && op_i == OAG_OP_MOVE_BYTE
    |=> ea_o[15:8] == TOP_PAGE_HI) else $error("short address not in top page");
  small_const_a : assert property (take && mode_i == OAG_MD_SMALLK && word_i
    && (op_i == OAG_OP_ADD_SMALL || op_i == OAG_OP_SUB_SMALL)
    |=> imm_o == ($past(k_two_i) ? STEP_WORD : STEP_BYTE)) else $error("small constant wrong");
  branch_target_a : assert property (take && mode_i == OAG_MD_PCREL && !word_i
    && (op_i == OAG_OP_BRANCH_COND || op_i == OAG_OP_BRANCH_SUB)
    |=> ea_o == (($past(pc_i) + $past(disp)) & EVEN_MASK)) else $error("branch target wrong");
  bit_select_a : assert property (take && mode_i == OAG_MD_BITNUM && op_i == OAG_OP_BIT && !word_i
    |=> bit_mask_o == 8'h01 << $past(bnum)) else $error("bit mask wrong");
  imm16_refuse_a : assert property (take && mode_i == OAG_MD_IMM16 && op_i != OAG_OP_MOVE_WORD
    |=> illegal_o && done_o && $stable(ea_o) && $stable(imm_o)) else $error("long immediate not refused");
  table_addr_a : assert property (take && mode_i == OAG_MD_MEMIND
    && !word_i && (op_i == OAG_OP_JUMP || op_i == OAG_OP_JUMP_SUB)
    |=> mem_rd_o && busy_o && mem_addr_o == {ZERO_PAGE_HI, $past(ib2_i) & 8'hFE}) else $error("table read wrong");
  indirect_even_a : assert property (mem_rd_o && mem_ack_i
    |=> done_o && !busy_o && ea_o == ($past(mem_data_i) & EVEN_MASK)) else $error("indirect target wrong");

  // Main scenarios reached
  cover property (take && mode_i == OAG_MD_MEMIND);
  cover property (done_o && illegal_o);
  cover property (take && mode_i == OAG_MD_PCREL);
endmodule

`default_nettype wire

/* File: verif/cpu_operand_address_generation_tb_top.sv */
// Self-checking bench for the operand and branch address generator
`timescale 1ns/1ps
`default_nettype none

module cpu_operand_address_generation_tb_top;
  import oag_pkg::*;
  logic clk_i = 0, rst_i = 1, req_i = 0, word_i = 0, k_two_i = 0, bit_in_b4_i = 0;
  logic dadj_c_i = 0, dadj_h_i = 0, mem_ack_i, busy_o, done_o, ptr_we_o, sp_used_o, mem_rd_o;
  logic illegal_o, vec_hit_o, dadj_c_o;
  oag_mode_t mode_i = OAG_MD_IMM8;
  oag_op_t op_i = OAG_OP_ALU_BYTE;
  logic [2:0] reg_sel_i = 3'h0, ptr_sel_o;
  logic [3:0] mem_dly = 4'h0;
  logic [7:0] ib2_i = 8'h00, dadj_val_i = 8'h00, bit_mask_o, dadj_o;
  logic [15:0] ptr_i = 16'h0000, pc_i = 16'h0000, ext_i = 16'h0000, mem_data_i;
  logic [15:0] ea_o, imm_o, ptr_wdata_o, mem_addr_o;
  int err_count = 0, n_tests = 0;

  always #12.5 clk_i = ~clk_i;

  oag_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .mode_i(mode_i), .op_i(op_i),
    .word_i(word_i), .reg_sel_i(reg_sel_i), .ptr_i(ptr_i), .pc_i(pc_i), .ib2_i(ib2_i), .ext_i(ext_i),
    .k_two_i(k_two_i), .bit_in_b4_i(bit_in_b4_i), .dadj_val_i(dadj_val_i), .dadj_c_i(dadj_c_i),
    .dadj_h_i(dadj_h_i), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .busy_o(busy_o),
    .done_o(done_o), .ea_o(ea_o), .imm_o(imm_o), .ptr_we_o(ptr_we_o), .ptr_sel_o(ptr_sel_o),
    .ptr_wdata_o(ptr_wdata_o), .sp_used_o(sp_used_o), .bit_mask_o(bit_mask_o), .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o), .illegal_o(illegal_o), .vec_hit_o(vec_hit_o), .dadj_o(dadj_o),
    .dadj_c_o(dadj_c_o));

  oag_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
    .dly_i(mem_dly), .ack_o(mem_ack_i), .data_o(mem_data_i));

  // ----------------------------------------
  // Shared request and compare tasks
  // ----------------------------------------
  task automatic conclude;
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Sample at the falling edge so the done pulse has settled
  task automatic run(input oag_mode_t m, input oag_op_t o, input logic w, input logic [15:0] p,
                     input logic [7:0] b2, input logic [15:0] x, input logic [1:0] f);
    int n;
    @(posedge clk_i);
    mode_i <= m; op_i <= o; word_i <= w; ptr_i <= p; pc_i <= p; ib2_i <= b2; ext_i <= x;
    k_two_i <= f[1]; bit_in_b4_i <= f[0]; req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (done_o !== 1'b1 && n < 40);
    if (n == 40)
    begin
      err_count++;
      conclude();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pointer;
    reg_sel_i <= 3'h7;
    run(OAG_MD_POSTINC, OAG_OP_MOVE_WORD, 1, 16'h1001, 8'h00, 16'h0000, 0);
    cmp(ea_o, 16'h1000);
    cmp(ptr_wdata_o, 16'h1003);
    cmp({13'h0000, ptr_we_o, sp_used_o, illegal_o}, 16'h0006);
    cmp({13'h0000, ptr_sel_o}, 16'h0007);
    run(OAG_MD_POSTINC, OAG_OP_MOVE_BYTE, 0, 16'h1001, 8'h00, 16'h0000, 0);
    cmp(ptr_wdata_o, 16'h1002);
    run(OAG_MD_PREDEC, OAG_OP_MOVE_BYTE, 0, 16'h2000, 8'h00, 16'h0000, 0);
    cmp(ea_o, 16'h1FFF);
    run(OAG_MD_PREDEC, OAG_OP_MOVE_WORD, 1, 16'h2000, 8'h00, 16'h0000, 0);
    cmp(ptr_wdata_o, 16'h1FFE);
  endtask

  task automatic t_absolute;
    run(OAG_MD_ABS8, OAG_OP_MOVE_BYTE, 0, 16'h0000, 8'h34, 16'h0000, 0);
    cmp(ea_o, 16'hFF34);
    run(OAG_MD_ABS16, OAG_OP_JUMP, 0, 16'h0000, 8'h00, 16'h1235, 0);
    cmp(ea_o, 16'h1234);
    run(OAG_MD_ABS16, OAG_OP_MOVE_BYTE, 0, 16'h0000, 8'h00, 16'h1235, 0);
    cmp(ea_o, 16'h1235);
  endtask

  task automatic t_immediate;
    run(OAG_MD_IMM8, OAG_OP_ALU_BYTE, 0, 16'h0000, 8'hA7, 16'h0000, 0);
    cmp(imm_o, 16'h00A7);
    run(OAG_MD_IMM16, OAG_OP_MOVE_WORD, 1, 16'h0000, 8'h00, 16'hBEEF, 0);
    cmp(imm_o, 16'hBEEF);
    run(OAG_MD_IMM16, OAG_OP_COMPARE_WORD, 1, 16'h0000, 8'h00, 16'h1234, 0);
    cmp({illegal_o, imm_o[14:0]}, 16'hBEEF);
  endtask

  // Both constants with both directions, then a refused byte form
  task automatic t_small;
    for (int i = 0; i < 4; i++)
    begin
      run(OAG_MD_SMALLK, i[0] ? OAG_OP_SUB_SMALL : OAG_OP_ADD_SMALL, 1, 0, 0, 0, {i[1], 1'b0});
      cmp(imm_o, i[1] ? 16'h0002 : 16'h0001);
    end
    run(OAG_MD_SMALLK, OAG_OP_SUB_SMALL, 0, 0, 0, 0, 0);
    cmp({15'h0000, illegal_o}, 16'h0001);
  endtask

  task automatic t_bits;
    for (int i = 0; i < 8; i++)
    begin
      // The unused byte carries the inverse number so a wrong source shows
      run(OAG_MD_BITNUM, OAG_OP_BIT, 0, 0, {1'b0, (i[0] ? ~i[2:0] : i[2:0]), 4'hF},
          {9'h000, (i[0] ? i[2:0] : ~i[2:0]), 4'h0}, {1'b0, i[0]});
      cmp({bit_mask_o, imm_o[7:0]}, {8'h01 << i, 8'(i)});
    end
  endtask

  task automatic t_branch;
    run(OAG_MD_PCREL, OAG_OP_BRANCH_COND, 0, 16'h0200, 8'h82, 0, 0);
    cmp(ea_o, 16'h0182);
    run(OAG_MD_PCREL, OAG_OP_BRANCH_COND, 0, 16'h0200, 8'h7F, 0, 0);
    cmp(ea_o, 16'h027E);
    run(OAG_MD_PCREL, OAG_OP_BRANCH_SUB, 0, 16'h0101, 8'h00, 0, 0);
    cmp(ea_o, 16'h0100);
  endtask

  // Slow answer on the second read, which also lands in the vector area
  task automatic t_indirect;
    run(OAG_MD_MEMIND, OAG_OP_JUMP, 0, 0, 8'h41, 0, 0);
    cmp({ea_o[15:1], vec_hit_o}, 16'h3140);
    mem_dly <= 4'h3;
    run(OAG_MD_MEMIND, OAG_OP_JUMP_SUB, 0, 0, 8'h20, 0, 0);
    cmp({ea_o[15:1], vec_hit_o}, 16'h3121);
  endtask

  // Reset lands while an indirect read still waits for its answer
  task automatic t_reset;
    mem_dly <= 4'h8;
    @(posedge clk_i);
    mode_i <= OAG_MD_MEMIND;
    op_i <= OAG_OP_JUMP;
    word_i <= 1'b0;
    ib2_i <= 8'h50;
    req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    @(negedge clk_i);
    cmp({15'h0000, busy_o}, 16'h0001);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(negedge clk_i);
    cmp({busy_o, mem_rd_o, ea_o[13:0]}, 16'h0000);
    @(posedge clk_i);
    rst_i <= 1'b0;
    mem_dly <= 4'h0;
  endtask

  task automatic t_sizes;
    dadj_val_i <= 8'h9A;
    run(OAG_MD_IMM8, OAG_OP_DEC_ADJ_ADD, 0, 0, 0, 0, 0);
    cmp({7'h00, dadj_c_o, dadj_o}, 16'h0100);
    dadj_val_i <= 8'h1B;
    dadj_h_i <= 1'b1;
    run(OAG_MD_IMM8, OAG_OP_DEC_ADJ_SUB, 0, 0, 0, 0, 0);
    cmp({7'h00, dadj_c_o, dadj_o}, 16'h0015);
    run(OAG_MD_IMM8, OAG_OP_MULTIPLY, 1, 0, 0, 0, 0);
    cmp({15'h0000, illegal_o}, 16'h0000);
    run(OAG_MD_IMM8, OAG_OP_ALU_BYTE, 1, 0, 0, 0, 0);
    cmp({15'h0000, illegal_o}, 16'h0001);
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_pointer();
    t_absolute();
    t_immediate();
    t_small();
    t_bits();
    t_branch();
    t_indirect();
    t_reset();
    t_sizes();
    conclude();
  end
endmodule

bind oag_core oag_core_properties chk_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .mode_i(mode_i),
  .op_i(op_i), .word_i(word_i), .k_two_i(k_two_i), .bit_in_b4_i(bit_in_b4_i), .ptr_i(ptr_i), .pc_i(pc_i),
  .ib2_i(ib2_i), .ext_i(ext_i), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .busy_o(busy_o),
  .done_o(done_o), .illegal_o(illegal_o), .mem_rd_o(mem_rd_o), .ea_o(ea_o), .imm_o(imm_o),
  .ptr_wdata_o(ptr_wdata_o), .bit_mask_o(bit_mask_o), .mem_addr_o(mem_addr_o));

`default_nettype wire
